// *** src/ppc_port.sv ***
// Parallel printer port: data latch, control latch and status channel
// on the host I/O space, plus the acknowledge interrupt request.
// Assumes all inputs are synchronous to clock and that cable-side
// inputs are given as cable levels.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1 - Control read bit 7 is switch four, reading 0 when on.
// R2 - Control read bit 6 is switch five, reading 0 when on.
// R3 - Control read bit 5 shows the disk-change line, 1 when door open.
// R4 - Drive keeps disk-change asserted until selected and stepped.
// R5 - Disk-change bit only meaningful while a drive is active and selected.
// R6 - With ack interrupt enabled, acknowledge requests level-7 interrupt.
// R7 - Control low four bits read as latch OR external cable drive.
// R8 - Reset loads control defaults, strobe inactive.
// R9 - Data should be present 1 us before strobe goes active.
// R10 - Data should stay valid 1 us after strobe goes inactive.
// R11 - Strobe pulse should last from 1 us to 500 us.
// R12 - Busy may be sampled right after strobe goes inactive.
// R13 - Status channel is read-only, unlatched; writes ignored.
// R14 - Status bits: busy inverted, ack, paper out, selected, error.
// R15 - Status bits 2..0 show option links inverted.
// R16 - Printer asserts busy whenever it cannot take data.
// R17 - Acknowledge signals byte received and ready for next.
// R18 - Control latch read/write: irq enable, select, not-reset, feed, strobe.
// R19 - Data latch is read/write eight bits driving cable data.
// R20 - Interrupt set on ack active edge, held until serviced, when enabled.
module pcs_port
  import pcs_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic [15:0]           io_addr,
  input  wire logic                  io_rd,
  input  wire logic                  io_wr,
  input  wire logic [7:0]            io_wdata,
  output var  logic [7:0]            io_rdata,
  output var  logic                  io_wr_ready,
  output var  logic [pcs_pkg::DATA_WIDTH-1:0] cable_data,
  output var  logic [3:0]            cable_ctl_n,
  input  wire logic [3:0]            cable_ctl_ext_n,
  input  wire logic                  cable_busy,
  input  wire logic                  cable_ack_n,
  input  wire logic                  cable_paper_out,
  input  wire logic                  cable_selected,
  input  wire logic                  cable_error_n,
  input  wire logic                  option_link_one,
  input  wire logic                  option_link_two,
  input  wire logic                  option_link_three,
  input  wire logic                  config_switch_four,
  input  wire logic                  config_switch_five,
  input  wire logic                  disk_change_line,
  input  wire logic                  irq_serviced,
  output var  logic                  irq_level7
);

  logic [4:0]            ctl;
  logic [4:0]            next_ctl;
  logic [DATA_WIDTH-1:0] data_latch;
  logic [DATA_WIDTH-1:0] next_data_latch;
  logic [7:0]            next_rdata;
  logic [3:0]            next_cable_ctl_n;
  logic                  ack_n_prev;
  logic                  next_irq;
  logic                  ack_edge;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [DATA_WIDTH-1:0] fifo_out_data;
  logic                  data_wr;
  logic [7:0]            ctl_read;
  logic [7:0]            status_read;

  ////////////////////////////////////////////////////////////////////////
  // Data path: bytes queue up and reach the cable only while strobe is
  // low, so the byte under an active strobe never changes.
  assign data_wr        = io_wr && (io_addr == DATA_REG_ADDR);
  assign fifo_out_ready = !ctl[CTL_STROBE];          // [R9] [R10]

  pcs_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (data_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (io_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign io_wr_ready = fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////
  // Read views
  always_comb
  begin
    ctl_read                 = 8'h00;
    ctl_read[CTL_SW_FOUR]    = !config_switch_four;                  // [R1]
    ctl_read[CTL_SW_FIVE]    = !config_switch_five;                  // [R2]
    // Raw level; software only trusts it with a drive selected
    ctl_read[CTL_DISK_CHG]   = disk_change_line;                // [R3] [R5]
    ctl_read[CTL_ACK_IRQ_EN] = ctl[CTL_ACK_IRQ_EN];
    // Cable control lines are active low on both drive sources
    ctl_read[3:0]            = ctl[3:0] | ~cable_ctl_ext_n;           // [R7]

    status_read                 = 8'h00;                         // [R13]
    status_read[STS_BUSY_N]     = !cable_busy;                   // [R14]
    status_read[STS_ACK_N]      = cable_ack_n;                   // [R14]
    status_read[STS_PAPER_OUT]  = cable_paper_out;               // [R14]
    status_read[STS_SELECTED]   = cable_selected;                // [R14]
    status_read[STS_ERROR_N]    = cable_error_n;                 // [R14]
    status_read[STS_LINK_THREE] = !option_link_three;            // [R15]
    status_read[STS_LINK_TWO]   = !option_link_two;              // [R15]
    status_read[STS_LINK_ONE]   = !option_link_one;              // [R15]
  end

  ////////////////////////////////////////////////////////////////////////
  // Control latch: written whole, low bits mirrored onto the cable
  always_comb
  begin
    next_ctl = ctl;
    if (io_wr && (io_addr == CTRL_REG_ADDR))
    begin
      next_ctl = io_wdata[4:0];                                   // [R18]
    end
    // Cable lines are active low, so the pins carry the inverse
    next_cable_ctl_n = ~next_ctl[3:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctl         <= CTL_RESET_VALUE;                             // [R8]
      cable_ctl_n <= ~CTL_RESET_VALUE[3:0];                       // [R8]
    end
    else
    begin
      ctl         <= next_ctl;
      cable_ctl_n <= next_cable_ctl_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data latch: takes the buffer head; the cable copy is its own flop
  // so the pins come straight from a register
  always_comb
  begin
    next_data_latch = data_latch;
    if (fifo_out_valid && fifo_out_ready)
    begin
      next_data_latch = fifo_out_data;                            // [R19]
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      data_latch <= DATA_RESET_VALUE;
      cable_data <= DATA_RESET_VALUE;
    end
    else
    begin
      data_latch <= next_data_latch;
      cable_data <= next_data_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data: registered, standing for the one cycle after the read
  always_comb
  begin
    next_rdata = READ_IDLE_VALUE;
    if (io_rd)
    begin
      case (io_addr)
        DATA_REG_ADDR:   next_rdata = data_latch;                 // [R19]
        STATUS_REG_ADDR: next_rdata = status_read;               // [R13]
        CTRL_REG_ADDR:   next_rdata = ctl_read;
        default:         next_rdata = READ_IDLE_VALUE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      io_rdata <= READ_IDLE_VALUE;
    end
    else
    begin
      io_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge interrupt
  always_comb
  begin
    ack_edge = ack_n_prev && !cable_ack_n;
    next_irq = irq_level7;
    // Set beats a simultaneous service; disabling drops the request
    if (!ctl[CTL_ACK_IRQ_EN])
    begin
      next_irq = 1'b0;                                           // [R20]
    end
    else if (ack_edge)
    begin
      next_irq = 1'b1;                                      // [R6] [R20]
    end
    else if (irq_serviced)
    begin
      next_irq = 1'b0;                                           // [R20]
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      // Idle level, so no false edge appears after reset
      ack_n_prev <= 1'b1;
      irq_level7 <= 1'b0;
    end
    else
    begin
      ack_n_prev <= cable_ack_n;
      irq_level7 <= next_irq;
    end
  end

endmodule // pcs_port

`default_nettype wire

// *** src/ppc_pkg.sv ***
// Package for the parallel printer port: I/O addresses, bit positions,
// reset values and buffer sizes.
// Assumes a byte-wide I/O space decoded on a 16-bit address.
package pcs_pkg;

  localparam logic [15:0] DATA_REG_ADDR   = 16'h0378;
  localparam logic [15:0] STATUS_REG_ADDR = 16'h0379;
  localparam logic [15:0] CTRL_REG_ADDR   = 16'h037a;

  // Control latch bit positions
  localparam int CTL_STROBE     = 0;
  localparam int CTL_AUTOFEED   = 1;
  localparam int CTL_NOT_RESET  = 2;
  localparam int CTL_SELECT     = 3;
  localparam int CTL_ACK_IRQ_EN = 4;
  localparam int CTL_DISK_CHG   = 5;
  localparam int CTL_SW_FIVE    = 6;
  localparam int CTL_SW_FOUR    = 7;

  // Status channel bit positions
  localparam int STS_LINK_ONE   = 0;
  localparam int STS_LINK_TWO   = 1;
  localparam int STS_LINK_THREE = 2;
  localparam int STS_ERROR_N    = 3;
  localparam int STS_SELECTED   = 4;
  localparam int STS_PAPER_OUT  = 5;
  localparam int STS_ACK_N      = 6;
  localparam int STS_BUSY_N     = 7;

  // Writable control bits after reset: only not-reset is true
  localparam logic [4:0] CTL_RESET_VALUE  = 5'h04;
  localparam logic [7:0] DATA_RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE  = 8'h00;

  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;

endpackage

// *** src/ppc_fifo.sv ***
// Small synchronous FIFO holding printer data bytes on their way to
// the data latch.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module pcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  // Flags are registered so in_ready and out_valid come straight from flops
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= (next_count != FULL_COUNT);
      out_valid <= (next_count != '0);
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      store[wr_ptr] <= in_data;
    end
  end

  assign out_data = store[rd_ptr];

endmodule // pcs_fifo

`default_nettype wire

// *** test/pcs_port_assertions.sv ***
// Checker for the printer port: read-back, control outputs, interrupt.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pcs_port_chk
  import pcs_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic [3:0]  cable_ctl_n,
  input wire logic [3:0]  cable_ctl_ext_n,
  input wire logic        cable_busy,
  input wire logic        cable_ack_n,
  input wire logic        cable_paper_out,
  input wire logic        cable_selected,
  input wire logic        cable_error_n,
  input wire logic        option_link_one,
  input wire logic        option_link_two,
  input wire logic        option_link_three,
  input wire logic        config_switch_four,
  input wire logic        config_switch_five,
  input wire logic        disk_change_line,
  input wire logic        irq_serviced,
  input wire logic        irq_level7
);
  import pcs_pkg::*;
  logic       en_q, ack_q, rd_ctl, rd_sts, wr_ctl, ack_set;
  logic [7:0] sts_now;
  logic [3:0] ctl_lo, wd_lo;
  logic [2:0] sw_now;
  assign rd_ctl  = io_rd && io_addr == CTRL_REG_ADDR;
  assign rd_sts  = io_rd && io_addr == STATUS_REG_ADDR;
  assign wr_ctl  = io_wr && io_addr == CTRL_REG_ADDR;
  assign ack_set = en_q && ack_q && !cable_ack_n;
  assign ctl_lo  = ~cable_ctl_n | ~cable_ctl_ext_n;
  assign wd_lo   = ~io_wdata[3:0];
  assign sw_now  = {~config_switch_four, ~config_switch_five,
                    disk_change_line};
  assign sts_now = {~cable_busy, cable_ack_n, cable_paper_out,
                    cable_selected, cable_error_n, ~option_link_three,
                    ~option_link_two, ~option_link_one};
  // Enable is not a port, so mirror it from control writes
  always_ff @(posedge clock)
  begin
    ack_q <= cable_ack_n;
    en_q  <= srst ? 1'b0 : (wr_ctl ? io_wdata[CTL_ACK_IRQ_EN] : en_q);
  end
  ////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_sts_map: assert property (
    rd_sts |=> io_rdata == $past(sts_now)) else $error("status bits");
  a_sw_disk: assert property (
    rd_ctl |=> io_rdata[7:5] == $past(sw_now)) else $error("switch bits");
  a_ctl_or: assert property (
    rd_ctl |=> io_rdata[3:0] == $past(ctl_lo)) else $error("control or");
  a_en_back: assert property (
    rd_ctl |=> io_rdata[4] == $past(en_q)) else $error("enable bit");
  a_ctl_write: assert property (
    wr_ctl |=> cable_ctl_n == $past(wd_lo)) else $error("control out");
  a_irq_set: assert property (
    ack_set |=> irq_level7) else $error("irq not raised");
  a_irq_clear: assert property (
    irq_serviced && !ack_set |=> !irq_level7) else $error("irq kept");
  a_irq_noen: assert property (
    !en_q |=> !irq_level7) else $error("irq while disabled");
endmodule // pcs_port_chk

bind pcs_port pcs_port_chk u_chk (
  .clock, .srst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
  .cable_ctl_n, .cable_ctl_ext_n, .cable_busy, .cable_ack_n,
  .cable_paper_out, .cable_selected, .cable_error_n, .option_link_one,
  .option_link_two, .option_link_three, .config_switch_four,
  .config_switch_five, .disk_change_line, .irq_serviced, .irq_level7);
`default_nettype wire

// *** test/pcs_printer.sv ***
// Printer on the cable: takes the byte as strobe ends, busy a while,
// then one acknowledge pulse. Assumes strobe held several cycles.
`timescale 1ns/1ps
`default_nettype none
module pcs_printer (
  input  wire logic       clock,
  input  wire logic [7:0] cable_data,
  input  wire logic       strobe_n,
  input  wire logic [7:0] busy_time,
  output logic            cable_busy,
  output logic            cable_ack_n,
  output logic [7:0]      last_byte
);
  logic [7:0] cnt = 8'h00;
  logic       stb_q = 1'b1;
  always @(posedge clock)
  begin
    // Unknown strobe before reset counts as idle, keeping the count clean
    stb_q <= (strobe_n !== 1'b0);
    if (!stb_q && strobe_n)
      last_byte <= cable_data;
    cnt <= (!stb_q && strobe_n) ? busy_time : cnt - {7'h0, cnt != 8'h00};
  end
  assign cable_busy  = cnt > 8'h01 || !stb_q;
  assign cable_ack_n = cnt != 8'h01;
endmodule // pcs_printer
`default_nettype wire

// *** test/tb_printer_port_control_status.sv ***
// Bench for the printer port: registers, data buffer, interrupt.
// Assumes the printer model drives busy and acknowledge.
`timescale 1ns/1ps
`default_nettype none
module tb_printer_port_control_status;
  import pcs_pkg::*;
  logic clock, srst, io_rd, io_wr, irq_serviced, sw4, sw5, dchg;
  logic cable_busy, cable_ack_n, io_wr_ready, irq_level7, paper, sel, err_n;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, cable_data, last_byte, busy_time, e;
  logic [3:0]  cable_ctl_n, ext_n;
  logic [2:0]  links;
  int          miscompares, checks, cycles;
  pcs_port dut (
    .clock, .srst, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
    .io_wr_ready, .cable_data, .cable_ctl_n, .cable_ctl_ext_n(ext_n),
    .cable_busy, .cable_ack_n, .cable_paper_out(paper),
    .cable_selected(sel), .cable_error_n(err_n),
    .option_link_one(links[0]), .option_link_two(links[1]),
    .option_link_three(links[2]), .config_switch_four(sw4),
    .config_switch_five(sw5), .disk_change_line(dchg), .irq_serviced,
    .irq_level7);
  pcs_printer u_prn (.clock, .cable_data, .strobe_n(cable_ctl_n[0]),
    .busy_time, .cable_busy, .cable_ack_n, .last_byte);
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      results();
    end
  end
  ////////////////////
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clock) #1;
    io_wr = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] x);
    @(posedge clock) #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clock) #1;
    io_rd = 1'b0;
    chk(io_rdata, x);
  endtask
  ////////////////////
  task automatic t_reset();
    chk({4'h0, cable_ctl_n}, 8'h0b);
    chk({6'h0, irq_level7, io_wr_ready}, 8'h01);
    rdc(CTRL_REG_ADDR, 8'h64);
  endtask
  task automatic t_ctl();
    for (int i = 0; i < 16; i++)
    begin
      {sw4, sw5, dchg} = i[2:0]; // drive taken as selected
      ext_n = ~i[3:0];
      wr(CTRL_REG_ADDR, {4'h0, i[3:0] ^ 4'h5});
      chk({4'h0, cable_ctl_n}, {4'h0, i[3:0] ^ 4'ha});
      e = {~i[2:1], i[0], 1'b0, i[3:0] | 4'h5};
      rdc(CTRL_REG_ADDR, e);
    end
    ext_n = 4'hf;
    wr(CTRL_REG_ADDR, 8'h04);
  endtask
  task automatic t_status();
    for (int i = 0; i < 8; i++)
    begin
      links = i[2:0];
      {paper, sel, err_n} = ~i[2:0];
      wr(STATUS_REG_ADDR, 8'hff);
      rdc(STATUS_REG_ADDR, {2'b11, ~i[2:0], ~i[2:0]});
    end
    rdc(16'h037b, 8'h00);
  endtask
  task automatic t_fifo();
    wr(CTRL_REG_ADDR, 8'h05);
    for (int k = 0; k < 5; k++)
      wr(DATA_REG_ADDR, 8'ha0 + k[7:0]);
    chk({7'h0, io_wr_ready}, 8'h00);
    wr(CTRL_REG_ADDR, 8'h04);
    repeat (10) @(posedge clock);
    #1 chk(cable_data, 8'ha3);
    chk({7'h0, io_wr_ready}, 8'h01);
    rdc(DATA_REG_ADDR, 8'ha3);
  endtask
  // A pending request is cleared by service, or by dropping the enable
  task automatic t_print(input logic [7:0] bt, input logic en,
                         input logic drop);
    busy_time = bt;
    wr(CTRL_REG_ADDR, {3'h0, en, 4'h4});
    wr(DATA_REG_ADDR, 8'h5a);
    repeat (10) @(posedge clock);
    wr(CTRL_REG_ADDR, {3'h0, en, 4'h5});
    repeat (10) @(posedge clock);
    wr(CTRL_REG_ADDR, {3'h0, en, 4'h4});
    rdc(STATUS_REG_ADDR, 8'h40);
    for (int k = 0; k < 100 && cable_ack_n; k++)
      @(posedge clock) #1;
    repeat (2) @(posedge clock);
    #1 chk({7'h0, irq_level7}, {7'h0, en});
    chk(last_byte, 8'h5a);
    if (drop)
    begin
      wr(CTRL_REG_ADDR, 8'h04);
      @(posedge clock) #1;
    end
    else
    begin
      @(posedge clock) #1 irq_serviced = 1'b1;
      @(posedge clock) #1 irq_serviced = 1'b0;
    end
    chk({7'h0, irq_level7}, 8'h00);
  endtask
  ////////////////////
  initial
  begin
    {srst, io_rd, io_wr, irq_serviced, sw4, sw5, dchg} = 7'b1000101;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    ext_n = 4'hf;
    links = 3'h0;
    {paper, sel, err_n} = 3'b001;
    busy_time = 8'h03;
    repeat (12) @(posedge clock);
    #1 srst = 1'b0;
    t_reset();
    t_ctl();
    t_status();
    t_fifo();
    t_print(8'd3, 1'b1, 1'b0);
    t_print(8'd40, 1'b1, 1'b1);
    t_print(8'd3, 1'b0, 1'b0);
    results();
  end
endmodule // tb_printer_port_control_status
`default_nettype wire
